// >>> cdpd_regs.svh
`ifndef CDPD_REGS_SVH
`define CDPD_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CDPD_OFS_DIV_CTRL      8'h00
`define CDPD_OFS_SYS_CTRL      8'h04
`define CDPD_OFS_HALT_HIGH     8'h08
`define CDPD_OFS_HALT_LOW      8'h0c
`define CDPD_OFS_STATUS        8'h10
`define CDPD_OFS_REFRESH_CNT   8'h14
`define CDPD_OFS_REFRESH_CS    8'h18

// ----------------------------------------
// Reset values and fixed bits
// ----------------------------------------
`define CDPD_RST_DIV_CTRL      8'hfc
`define CDPD_RST_SYS_CTRL      8'h09
`define CDPD_RST_HALT_HIGH     8'h78
`define CDPD_RST_HALT_LOW      8'h00
`define CDPD_DIV_FIXED_ONES    6'h3f
`define CDPD_HALT_HIGH_ONES    8'h78

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CDPD_SYS_STANDBY_BIT   7
`define CDPD_SYS_WAIT_MSB      6
`define CDPD_SYS_WAIT_LSB      4
`define CDPD_SYS_MEM_EN_BIT    0
`define CDPD_HIGH_CLK_STOP_BIT 7
`define CDPD_HIGH_SERIAL2_BIT  2
`define CDPD_HIGH_SERIAL1_BIT  1
`define CDPD_HIGH_SERIAL0_BIT  0
`define CDPD_LOW_DMA_BIT       7
`define CDPD_LOW_DRAM_BIT      5
`define CDPD_LOW_TMR16_BIT     4
`define CDPD_LOW_TMR8_BIT      3
`define CDPD_LOW_ADC_BIT       0
`define CDPD_REFRESH_CLR_MASK  8'h3f

// ----------------------------------------
// Wake wait, in states
// ----------------------------------------
`define CDPD_WAIT_BASE_STATES  8192
`define CDPD_WAIT_SHORT_STATES 1024
`define CDPD_WAIT_SHORT_CODE   3'h6
`define CDPD_WAIT_BAD_CODE     3'h7
`define CDPD_WAIT_MAX_SHIFT    5

`endif

// >>> cdpd_pkg.sv
package cdpd_pkg;

    typedef enum logic [2:0] {
        CDPD_RUN,
        CDPD_SLEEP,
        CDPD_SW_STANDBY,
        CDPD_WAKE_WAIT,
        CDPD_HW_STANDBY
    } cdpd_power_e;

    typedef logic [7:0] cdpd_byte_t;

endpackage

// >>> cdpd_divider.sv
`timescale 1ns/10ps

module cdpd_divider
    import cdpd_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // Control
    input  wire logic       run,
    input  wire logic [1:0] ratio,
    // Divided clock
    output logic            tick,
    output logic            phi_level,
    output logic [1:0]      ratio_now
);

    logic [2:0] cnt;
    logic [2:0] limit;
    logic [2:0] half;

    assign limit = 3'((4'h1 << ratio_now) - 4'h1);
    assign half  = 3'((4'h1 << ratio_now) >> 1);
    assign tick  = run && (cnt == limit);

    // ----------------------------------------
    // Period counter; ratio taken only at a period end
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cnt       <= 3'h0;
            ratio_now <= 2'h0;
        end else if (tick) begin
            cnt       <= 3'h0;
            ratio_now <= ratio;             // [R16] [R18]
        end else if (run) begin
            cnt       <= cnt + 3'h1;
        end else begin
            cnt       <= 3'h0;
        end
    end

    // ----------------------------------------
    // Pin level: high first half, held high when stopped
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            phi_level <= 1'b1;
        end else if (!run || tick) begin
            phi_level <= 1'b1;
        end else if (3'(cnt + 3'h1) == half) begin
            phi_level <= 1'b0;
        end
    end

endmodule

// >>> cdpd_top.sv
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
`include "cdpd_regs.svh"

// Notes on behaviour
// [R1] Division register is read/write; reset and hardware standby reload it, software standby keeps.
// [R2] Division register bits 7 to 2 read as one and ignore writes.
// [R3] Ratio select 00,01,10,11 gives 1/1,1/2,1/4,1/8; reset gives 1/1.
// [R4] Every module runs from the divided clock, including the wake wait count.
// [R5] Software keeps the divided clock within its operating range.
// [R6] Sleep instruction with standby select clear halts only the CPU.
// [R7] Sleep ends on any interrupt, reset pin or hardware halt pin.
// [R8] Sleep with standby select set stops clock, resets modules, drives clock pin high.
// [R9] Entering software standby clears refresh counter and refresh status bits 7 and 6.
// [R10] Hardware halt pin low stops all, resets modules, floats clock pin and ports.
// [R11] Software clears the memory enable bit before pulling the hardware halt pin low.
// [R12] A set module halt bit halts and resets only that module.
// [R13] Eight units can be halted: timers, three serial, DMA, DRAM, converter.
// [R14] Setting a halt bit reinitialises the module; software clears then reprograms it.
// [R15] Module halt ends on bit clear, hardware halt pin or reset.
// [R16] Divider works from the duty-adjusted clock; ratio may change any time.
// [R17] Leaving software standby by pin interrupt waits a selected number of states.
// [R18] New ratio applies only at a period boundary, so no short pulse.

module cdpd_top
    import cdpd_pkg::*;
#(
    parameter int WAIT_BASE  = `CDPD_WAIT_BASE_STATES,
    parameter int WAIT_SHORT = `CDPD_WAIT_SHORT_STATES
)
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // APB slave
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [7:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic            pready,
    output logic [31:0]     prdata,
    output logic            pslverr,
    // Pins
    input  wire logic       hw_halt_pin_n,
    input  wire logic       nmi_pin_n,
    input  wire logic [2:0] irq_pin_n,
    // CPU side
    input  wire logic       sleep_exec,
    input  wire logic       irq_any,
    output logic            cpu_halt,
    output logic            cpu_regs_lost,
    output logic            onchip_memory_enable,
    // Module side
    output logic            phi_tick,
    output logic [7:0]      module_halt,
    output logic [7:0]      module_clear,
    output logic [7:0]      refresh_counter,
    output logic [7:0]      refresh_control_status,
    output logic            ports_float,
    // Clock pin
    output logic            phi_pin_out,
    output logic            phi_pin_oe
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pin_meta <= 5'h1f;
            pin_sync <= 5'h1f;
        end else begin
            pin_meta <= {hw_halt_pin_n, nmi_pin_n, irq_pin_n};
            pin_sync <= pin_meta;
        end
    end

    logic hw_halt_req;
    logic pin_wake;

    assign hw_halt_req = !pin_sync[4];
    assign pin_wake    = !(&pin_sync[3:0]);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [1:0]  ratio_select;
    cdpd_byte_t  system_control_register;
    cdpd_byte_t  module_halt_register_high;
    cdpd_byte_t  module_halt_register_low;
    cdpd_power_e state;
    cdpd_power_e next_state;
    logic        hw_clear;
    logic        sw_entry;
    logic        wr_en;
    logic        rd_setup;
    logic        mapped;

    assign hw_clear = (state == CDPD_HW_STANDBY);
    assign sw_entry = (state != CDPD_SW_STANDBY) && (next_state == CDPD_SW_STANDBY);
    assign wr_en    = psel && penable && pwrite && !hw_clear;
    assign rd_setup = psel && !penable;

    always_comb begin
        case (paddr)
            `CDPD_OFS_DIV_CTRL,
            `CDPD_OFS_SYS_CTRL,
            `CDPD_OFS_HALT_HIGH,
            `CDPD_OFS_HALT_LOW,
            `CDPD_OFS_STATUS,
            `CDPD_OFS_REFRESH_CNT,
            `CDPD_OFS_REFRESH_CS: mapped = 1'b1;
            default:              mapped = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Division ratio
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset || hw_clear) begin
            ratio_select <= 2'(`CDPD_RST_DIV_CTRL);   // [R1] [R3]
        end else if (wr_en && paddr == `CDPD_OFS_DIV_CTRL) begin
            ratio_select <= pwdata[1:0];              // [R2] [R16]
        end
    end

    // ----------------------------------------
    // System control
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset || hw_clear) begin
            system_control_register <= `CDPD_RST_SYS_CTRL;
        end else if (wr_en && paddr == `CDPD_OFS_SYS_CTRL) begin
            system_control_register <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // Module halt registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset || hw_clear) begin
            module_halt_register_high <= `CDPD_RST_HALT_HIGH;  // [R15]
            module_halt_register_low  <= `CDPD_RST_HALT_LOW;
        end else if (wr_en && paddr == `CDPD_OFS_HALT_HIGH) begin
            module_halt_register_high <= pwdata[7:0] | `CDPD_HALT_HIGH_ONES;
        end else if (wr_en && paddr == `CDPD_OFS_HALT_LOW) begin
            module_halt_register_low  <= pwdata[7:0];
        end
    end

    logic standby_select_bit;
    logic [2:0] wake_wait_select;
    logic clock_out_stop;

    assign standby_select_bit   = system_control_register[`CDPD_SYS_STANDBY_BIT];
    assign wake_wait_select     = system_control_register[`CDPD_SYS_WAIT_MSB:`CDPD_SYS_WAIT_LSB];
    assign onchip_memory_enable = system_control_register[`CDPD_SYS_MEM_EN_BIT];
    assign clock_out_stop       = module_halt_register_high[`CDPD_HIGH_CLK_STOP_BIT];

    // ----------------------------------------
    // Module halt bits, one per unit
    // ----------------------------------------
    logic [7:0] module_halt_bits;

    assign module_halt_bits = {                      // [R13]
        module_halt_register_low[`CDPD_LOW_ADC_BIT],
        module_halt_register_low[`CDPD_LOW_DRAM_BIT],
        module_halt_register_low[`CDPD_LOW_DMA_BIT],
        module_halt_register_high[`CDPD_HIGH_SERIAL2_BIT],
        module_halt_register_high[`CDPD_HIGH_SERIAL1_BIT],
        module_halt_register_high[`CDPD_HIGH_SERIAL0_BIT],
        module_halt_register_low[`CDPD_LOW_TMR8_BIT],
        module_halt_register_low[`CDPD_LOW_TMR16_BIT]
    };

    localparam int DRAM_UNIT = 6;

    // ----------------------------------------
    // Frequency divider
    // ----------------------------------------
    logic       clock_run;
    logic       div_tick;
    logic       div_level;
    logic [1:0] ratio_now;

    assign clock_run = (state != CDPD_SW_STANDBY) && (state != CDPD_HW_STANDBY);

    cdpd_divider u_divider (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .run       (clock_run),
        .ratio     (ratio_select),
        .tick      (div_tick),
        .phi_level (div_level),
        .ratio_now (ratio_now)
    );

    // ----------------------------------------
    // Wake wait length
    // ----------------------------------------
    logic [18:0] wait_len;
    logic [18:0] wait_cnt;

    always_comb begin
        case (wake_wait_select)
            `CDPD_WAIT_SHORT_CODE: wait_len = 19'(WAIT_SHORT);
            `CDPD_WAIT_BAD_CODE:   wait_len = 19'(WAIT_BASE << `CDPD_WAIT_MAX_SHIFT);
            default:               wait_len = 19'(WAIT_BASE << wake_wait_select);   // [R17]
        endcase
    end

    // ----------------------------------------
    // Power state machine
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            CDPD_RUN: begin
                if (sleep_exec && standby_select_bit) begin
                    next_state = CDPD_SW_STANDBY;     // [R8]
                end else if (sleep_exec) begin
                    next_state = CDPD_SLEEP;          // [R6]
                end
            end
            CDPD_SLEEP: begin
                if (irq_any) begin
                    next_state = CDPD_RUN;            // [R7]
                end
            end
            CDPD_SW_STANDBY: begin
                if (pin_wake) begin
                    next_state = CDPD_WAKE_WAIT;      // [R17]
                end
            end
            CDPD_WAKE_WAIT: begin
                if (div_tick && wait_cnt == 19'h0) begin
                    next_state = CDPD_RUN;            // [R4] [R17]
                end
            end
            CDPD_HW_STANDBY: begin
                next_state = CDPD_RUN;                // [R10]
            end
            default: begin
                next_state = CDPD_RUN;
            end
        endcase
        if (hw_halt_req) begin
            next_state = CDPD_HW_STANDBY;             // [R7] [R10] [R15]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= CDPD_RUN;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Wake wait counter, counted in divided states
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wait_cnt <= 19'h0;
        end else if (state == CDPD_SW_STANDBY) begin
            wait_cnt <= 19'(wait_len - 19'h1);
        end else if (state == CDPD_WAKE_WAIT && div_tick && wait_cnt != 19'h0) begin
            wait_cnt <= wait_cnt - 19'h1;             // [R4]
        end
    end

    // ----------------------------------------
    // Refresh interface state
    // ----------------------------------------
    logic dram_clear;

    assign dram_clear = module_halt_bits[DRAM_UNIT] || hw_clear;

    always_ff @(posedge sys_clk) begin
        if (reset || dram_clear) begin
            refresh_counter <= 8'h00;                 // [R12]
        end else if (sw_entry) begin
            refresh_counter <= 8'h00;                 // [R9]
        end else if (wr_en && paddr == `CDPD_OFS_REFRESH_CNT) begin
            refresh_counter <= pwdata[7:0];
        end else if (phi_tick) begin
            refresh_counter <= refresh_counter + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || dram_clear) begin
            refresh_control_status <= 8'h00;
        end else if (sw_entry) begin
            refresh_control_status <= refresh_control_status & `CDPD_REFRESH_CLR_MASK;  // [R9]
        end else if (wr_en && paddr == `CDPD_OFS_REFRESH_CS) begin
            refresh_control_status <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // CPU and module controls
    // ----------------------------------------
    logic       all_halt;
    logic [7:0] next_module_halt;
    logic [7:0] next_module_clear;

    assign all_halt = !clock_run || (state == CDPD_WAKE_WAIT);
    assign phi_tick = div_tick && (state == CDPD_RUN || state == CDPD_SLEEP);   // [R4] [R6]

    always_comb begin
        next_module_halt  = module_halt_bits | {8{all_halt}};              // [R12]
        next_module_clear = module_halt_bits | {8{all_halt}};              // [R14]
        if (state == CDPD_SW_STANDBY || state == CDPD_WAKE_WAIT) begin
            next_module_clear[DRAM_UNIT] = module_halt_bits[DRAM_UNIT];    // [R8]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            module_halt  <= 8'h00;
            module_clear <= 8'h00;
        end else begin
            module_halt  <= next_module_halt;         // [R12] [R15]
            module_clear <= next_module_clear;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cpu_halt <= 1'b0;
        end else begin
            cpu_halt <= (next_state != CDPD_RUN);    // [R6] [R8]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cpu_regs_lost <= 1'b0;
        end else if (hw_clear) begin
            cpu_regs_lost <= 1'b1;                    // [R10]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ports_float <= 1'b0;
        end else begin
            ports_float <= (next_state == CDPD_HW_STANDBY);  // [R10]
        end
    end

    // ----------------------------------------
    // Clock pin
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            phi_pin_out <= 1'b1;
            phi_pin_oe  <= 1'b1;
        end else begin
            phi_pin_out <= div_level || !clock_run;   // [R8]
            phi_pin_oe  <= !hw_clear && !clock_out_stop && !hw_halt_req;  // [R10]
        end
    end

    // ----------------------------------------
    // APB read path
    // ----------------------------------------
    cdpd_byte_t rd_byte;

    always_comb begin
        case (paddr)
            `CDPD_OFS_DIV_CTRL:    rd_byte = {`CDPD_DIV_FIXED_ONES, ratio_select};   // [R2]
            `CDPD_OFS_SYS_CTRL:    rd_byte = system_control_register;
            `CDPD_OFS_HALT_HIGH:   rd_byte = module_halt_register_high;
            `CDPD_OFS_HALT_LOW:    rd_byte = module_halt_register_low;
            `CDPD_OFS_STATUS:      rd_byte = {1'b0, hw_halt_req, ratio_now, 1'b0, state};
            `CDPD_OFS_REFRESH_CNT: rd_byte = refresh_counter;
            `CDPD_OFS_REFRESH_CS:  rd_byte = refresh_control_status;
            default:               rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    assign pready  = psel && penable;
    assign pslverr = psel && penable && !mapped;

endmodule

// >>> cdpd_top_properties.sv
`timescale 1ns/10ps

module cdpd_top_properties
    import cdpd_pkg::*;
#(
    parameter int WAIT_BASE  = 8192,
    parameter int WAIT_SHORT = 1024
)
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    // Power control
    input wire logic        sleep_exec,
    input wire logic        irq_any,
    input wire logic        cpu_halt,
    input wire logic        cpu_regs_lost,
    input wire logic        phi_tick,
    input wire logic [7:0]  module_halt,
    input wire logic [7:0]  module_clear,
    input wire logic [7:0]  refresh_counter,
    input wire logic [7:0]  refresh_control_status,
    input wire logic        ports_float,
    input wire logic        phi_pin_oe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    a_apb_zero_wait: assert property (psel && penable |-> pready)
        else $error("access phase without pready");
    a_div_fixed_ones: assert property (psel && !penable && !pwrite && paddr == 8'h00
        |=> prdata == {24'h0, 6'h3f, prdata[1:0]})
        else $error("division read lost its fixed ones");
    a_sleep_entry_halt: assert property (sleep_exec && !cpu_halt |=> cpu_halt)
        else $error("sleep did not halt the cpu");
    a_sleep_irq_exit: assert property (cpu_halt && irq_any && !ports_float && module_halt != 8'hff
        |-> ##[1:2] !cpu_halt)
        else $error("interrupt did not end sleep");
    a_standby_refresh: assert property ($rose(module_halt == 8'hff) && cpu_halt && !ports_float
        |-> ##[0:2] (refresh_counter == 8'h00 && refresh_control_status[7:6] == 2'b00))
        else $error("refresh state kept on standby entry");
    a_clear_tracks_halt: assert property (!cpu_halt && !$past(cpu_halt) && !$past(cpu_halt, 2)
        |-> module_clear == module_halt)
        else $error("module clear differs from halt while running");
    a_hw_standby_out: assert property (ports_float && $past(ports_float)
        |-> !phi_pin_oe && module_halt == 8'hff && module_clear == 8'hff)
        else $error("hardware standby outputs wrong");
    a_hw_regs_lost: assert property ($rose(ports_float) |-> ##[0:1] cpu_regs_lost)
        else $error("cpu registers not marked lost");
endmodule

bind cdpd_top cdpd_top_properties #(
    .WAIT_BASE (WAIT_BASE),
    .WAIT_SHORT(WAIT_SHORT)
) cdpd_top_properties_inst (
    .sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .sleep_exec,
    .irq_any, .cpu_halt, .cpu_regs_lost, .phi_tick, .module_halt, .module_clear,
    .refresh_counter, .refresh_control_status, .ports_float, .phi_pin_oe
);

// >>> cdpd_cpu_model.sv
`timescale 1ns/10ps

module cdpd_cpu_model
    import cdpd_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // Bench commands
    input  wire logic sleep_req,
    input  wire logic wake_req,
    // Power controller
    input  wire logic cpu_halt,
    output logic      sleep_exec,
    output logic      irq_any
);
    // ----------------------------------------
    // One sleep instruction while running
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sleep_exec <= 1'b0;
        end else begin
            sleep_exec <= sleep_req && !cpu_halt && !sleep_exec;
        end
    end

    // Interrupt raised only while halted
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_any <= 1'b0;
        end else begin
            irq_any <= wake_req && cpu_halt;
        end
    end
endmodule

// >>> cdpd_top_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module cdpd_top_tb;
    import cdpd_pkg::*;
    logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr, se;
    logic        hw_halt_pin_n, nmi_pin_n, sleep_req, wake_req, sleep_exec, irq_any;
    logic        cpu_halt, cpu_regs_lost, onchip_memory_enable, phi_tick, ports_float;
    logic        phi_pin_out, phi_pin_oe;
    logic [2:0]  irq_pin_n, sel;
    logic [7:0]  paddr, rd, wv, module_halt, module_clear, refresh_counter, refresh_control_status;
    logic [15:0] v;
    logic [31:0] pwdata, prdata;
    int          fails, checks, seed, n, per;

    cdpd_top #(.WAIT_BASE(8), .WAIT_SHORT(2)) cdpd_top_inst (
        .sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .hw_halt_pin_n, .nmi_pin_n, .irq_pin_n, .sleep_exec, .irq_any, .cpu_halt, .cpu_regs_lost,
        .onchip_memory_enable, .phi_tick, .module_halt, .module_clear, .refresh_counter,
        .refresh_control_status, .ports_float, .phi_pin_out, .phi_pin_oe
    );
    cdpd_cpu_model cdpd_cpu_model_inst (
        .sys_clk, .reset, .sleep_req, .wake_req, .cpu_halt, .sleep_exec, .irq_any
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Expectations and bus cycles
    // ----------------------------------------
    function automatic logic [7:0] exp_halt(logic [15:0] b);
        return {b[0], b[5], b[7], b[10], b[9], b[8], b[3], b[4]};
    endfunction

    function automatic int wake_len(logic [2:0] s, int p);
        return ((s == 3'h6) ? 2 : (8 << ((s == 3'h7) ? 3'h5 : s))) * p;
    endfunction

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata[7:0];
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK("register", e, rd)
    endtask

    task automatic wait_halt(input logic h);
        n = 0;
        while (cpu_halt !== h && n < 4000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask

    task automatic period(output int p);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (phi_tick !== 1'b1 && n < 50);
        p = 0;
        do begin
            @(posedge sys_clk);
            p++;
        end while (phi_tick !== 1'b1 && p < 50);
    endtask

    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #(25 * 60000);
        fails++;
        close_out;
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        seed = 32'hb62793a4;
        {fails, checks} = 0;
        {reset, hw_halt_pin_n, nmi_pin_n, irq_pin_n} = 6'h3f;
        {psel, penable, pwrite, sleep_req, wake_req, paddr, pwdata} = '0;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rchk(8'h00, 8'hfc);
        rchk(8'h04, 8'h09);
        rchk(8'h08, 8'h78);
        rchk(8'h0c, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wv = (i < 4) ? i[7:0] : 8'($random(seed));
            apb(1'b1, 8'h00, wv);
            rchk(8'h00, {6'h3f, wv[1:0]});
            period(per);
            period(per);
            `CHK("period", 1 << wv[1:0], per)
            rchk(8'h10, {2'b00, wv[1:0], 4'h0});
        end
        apb(1'b0, 8'h1c, 8'h00);
        `CHK("slverr", 1'b1, se)
        for (int i = 0; i < 18; i++) begin
            v = (i < 16) ? 16'h1 << i : 16'($random(seed));
            apb(1'b1, 8'h08, v[15:8]);
            apb(1'b1, 8'h0c, v[7:0]);
            repeat (2) @(posedge sys_clk);
            `CHK("halt", exp_halt(v), module_halt)
            `CHK("clear", exp_halt(v), module_clear)
            `CHK("cpu", 1'b0, cpu_halt)
            rchk(8'h08, v[15:8] | 8'h78);
            rchk(8'h0c, v[7:0]);
        end
        apb(1'b1, 8'h08, 8'h00);
        apb(1'b1, 8'h0c, 8'h00);
        repeat (2) @(posedge sys_clk);
        `CHK("halt off", 8'h00, module_halt)
        apb(1'b1, 8'h04, 8'h01);
        sleep_req <= 1'b1;
        wait_halt(1'b1);
        sleep_req <= 1'b0;
        period(per);
        `CHK("sleep tick", 1 << wv[1:0], per)
        rchk(8'h10, {2'b00, wv[1:0], 4'h1});
        wake_req <= 1'b1;
        wait_halt(1'b0);
        wake_req <= 1'b0;
        `CHK("sleep exit", 1'b1, n < 8)
        for (int i = 0; i < 3; i++) begin
            sel = (i == 2) ? 3'h6 : i[2:0];
            apb(1'b1, 8'h18, 8'hff);
            apb(1'b1, 8'h04, {1'b1, sel, 4'h1});
            sleep_req <= 1'b1;
            wait_halt(1'b1);
            sleep_req <= 1'b0;
            repeat (3) @(posedge sys_clk);
            `CHK("sw halt", 8'hff, module_halt)
            `CHK("phi pin", 1'b1, phi_pin_out)
            `CHK("refresh", 8'h00, refresh_counter)
            `CHK("refresh cs", 8'h3f, refresh_control_status)
            {irq_pin_n, nmi_pin_n} <= ~((i == 2) ? 4'h8 : 4'h1 << i);
            wait_halt(1'b0);
            {irq_pin_n, nmi_pin_n} <= 4'hf;
            per = wake_len(sel, 1 << wv[1:0]);
            `CHK("wake wait", 1'b1, n >= per && n <= per + 12)
            rchk(8'h00, {6'h3f, wv[1:0]});
            rchk(8'h04, {1'b1, sel, 4'h1});
        end
        apb(1'b1, 8'h04, 8'h00);
        apb(1'b1, 8'h0c, 8'h80);
        `CHK("mem en", 1'b0, onchip_memory_enable)
        hw_halt_pin_n <= 1'b0;
        wait_halt(1'b1);
        repeat (4) @(posedge sys_clk);
        `CHK("float", 1'b1, ports_float)
        apb(1'b1, 8'h00, 8'h03);
        hw_halt_pin_n <= 1'b1;
        wait_halt(1'b0);
        repeat (2) @(posedge sys_clk);
        `CHK("lost", 1'b1, cpu_regs_lost)
        `CHK("units", 8'h00, module_halt)
        rchk(8'h00, 8'hfc);
        rchk(8'h0c, 8'h00);
        apb(1'b1, 8'h00, 8'h02);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK("lost clr", 1'b0, cpu_regs_lost)
        rchk(8'h00, 8'hfc);
        close_out;
    end
endmodule
